// ---- src/sbc_bank.sv ----
// Purpose: state register and timer of one bank
// Assumes: commands arrive decoded and gated by the device mode
// Notes: one instance per bank
`timescale 1ns/1ps
module sbc_bank
   import sbc_pkg::*;
#(
   parameter int RCD_C = T_RCD_C,
   parameter int RP_C = T_RP_C,
   parameter int WR_C = T_WR_C,
   parameter int BL_C = BURST_LEN
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire sbc_bank_ctl_t ctl,
   output sbc_bank_st_t state,
   output logic illegal
);
   localparam sbc_tmr_t LD_RCD = sbc_tmr_t'(RCD_C - 1);
   localparam sbc_tmr_t LD_RP = sbc_tmr_t'(RP_C - 1);
   localparam sbc_tmr_t LD_WRP = sbc_tmr_t'(WR_C + RP_C - 1);
   localparam sbc_tmr_t LD_BL = sbc_tmr_t'(BL_C - 1);

   sbc_bank_st_t state_reg, state_next;
   sbc_tmr_t tmr_reg, tmr_next;
   logic done, own_act, own_rd, own_wr, own_pre, own_exec;

   assign done = (tmr_reg == TMR_ZERO);
   assign own_act = ctl.hit && (ctl.cmd == CMD_ACT);
   assign own_rd = ctl.hit && (ctl.cmd == CMD_READ);
   assign own_wr = ctl.hit && (ctl.cmd == CMD_WRITE);
   assign own_pre = ctl.hit && (ctl.cmd == CMD_PRE);
   assign own_exec = own_act || own_rd || own_wr || own_pre;
   assign state = state_reg;

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      state_next = state_reg;
      tmr_next = done ? tmr_reg : sbc_tmr_t'(tmr_reg - TMR_ONE);
      illegal = 1'b0;
      case (state_reg)
         BK_IDLE: begin
            illegal = own_rd || own_wr; // [RL27] [RL10]
            if (own_act) begin
               state_next = BK_ACTIVATING; // [RL9] [RL15]
               tmr_next = LD_RCD;
            end
         end
         BK_ACTIVATING: begin
            illegal = own_exec; // [RL27]
            if (done) state_next = BK_ACTIVE; // [RL15]
         end
         BK_ACTIVE, BK_READ, BK_WRITE: begin
            illegal = own_act; // [RL27]
            if (own_rd || own_wr) begin
               state_next = own_rd ? (ctl.ap ? BK_READ_AP : BK_READ)
                                   : (ctl.ap ? BK_WRITE_AP : BK_WRITE); // [RL12] [RL13]
               tmr_next = LD_BL;
            end else if (own_pre) begin
               state_next = BK_PRECHARGING; // [RL13]
               tmr_next = LD_RP;
            end else if (state_reg != BK_ACTIVE && (ctl.bst || done)) begin
               state_next = BK_ACTIVE; // [RL1]
            end
         end
         BK_READ_AP, BK_WRITE_AP: begin
            illegal = own_exec; // [RL27]
            if (ctl.intr || done) begin
               state_next = BK_PRECHARGING; // [RL16] [RL23]
               tmr_next = (state_reg == BK_WRITE_AP) ? LD_WRP : LD_RP;
            end
         end
         BK_PRECHARGING: begin
            illegal = own_exec; // [RL27]
            if (done) state_next = BK_IDLE; // [RL14]
         end
         default: state_next = BK_IDLE;
      endcase
      if (ctl.pre_all && state_reg != BK_IDLE) begin
         state_next = BK_PRECHARGING;
         tmr_next = LD_RP;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= BK_IDLE;
         tmr_reg <= TMR_ZERO;
      end else if (ce) begin
         state_reg <= state_next;
         tmr_reg <= tmr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_idle_pre_nop: // [RL10]
      assert property (@(posedge mclk) disable iff (rst)
         ce && state_reg == BK_IDLE && own_pre && !ctl.pre_all |=> state_reg == BK_IDLE)
      else $error("precharge changed an idle bank");
   a_act_opens_row: // [RL15]
      assert property (@(posedge mclk) disable iff (rst)
         ce && state_reg == BK_IDLE && own_act |=> state_reg == BK_ACTIVATING && tmr_reg == LD_RCD)
      else $error("activate did not start row activation");
   a_pre_ends_idle: // [RL14]
      assert property (@(posedge mclk) disable iff (rst)
         ce && state_reg == BK_PRECHARGING && done && !ctl.pre_all |=> state_reg == BK_IDLE)
      else $error("precharging bank did not return to idle");
   a_ap_intr_pre: // [RL23]
      assert property (@(posedge mclk) disable iff (rst)
         ce && (state_reg == BK_READ_AP || state_reg == BK_WRITE_AP) && ctl.intr
         |=> state_reg == BK_PRECHARGING)
      else $error("interrupted auto precharge burst did not precharge");
endmodule

// ---- src/sbc_pkg.sv ----
// Purpose: shared constants and types of the bank command block
// Assumes: one 25 MHz clock, four banks
// Notes: times are in ns, cycle counts derived by rounding up
package sbc_pkg;
   localparam int CLK_NS = 40;
   localparam int T_RCD_NS = 20;
   localparam int T_RP_NS = 20;
   localparam int T_RFC_NS = 80;
   localparam int T_MRD_NS = 80;
   localparam int T_XSR_NS = 120;
   localparam int T_WR_NS = 15;
   localparam int T_RCD_C = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_RP_C = (T_RP_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_RFC_C = (T_RFC_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_MRD_C = (T_MRD_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_XSR_C = (T_XSR_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_WR_C = (T_WR_NS + CLK_NS - 1) / CLK_NS;
   localparam int CAS_LAT = 3;
   localparam int BURST_LEN = 4;
   localparam int SREF_INT_C = 64;
   localparam int NUM_BANKS = 4;
   localparam int BA_W = 2;
   localparam int ROW_W = 13;
   localparam int ADDR_W = 13;
   localparam int AP_BIT = 10;
   localparam int TMR_W = 8;

   typedef logic [TMR_W-1:0] sbc_tmr_t;
   typedef logic [BA_W-1:0] sbc_ba_t;
   typedef logic [ROW_W-1:0] sbc_row_t;
   localparam sbc_tmr_t TMR_ZERO = 8'h00;
   localparam sbc_tmr_t TMR_ONE = 8'h01;
   localparam sbc_row_t ROW_ZERO = 13'h0000;
   localparam sbc_row_t ROW_ONE = 13'h0001;

   // Pin patterns as {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] ENC_NOP = 4'h7;
   localparam logic [3:0] ENC_ACT = 4'h3;
   localparam logic [3:0] ENC_READ = 4'h5;
   localparam logic [3:0] ENC_WRITE = 4'h4;
   localparam logic [3:0] ENC_BST = 4'h6;
   localparam logic [3:0] ENC_PRE = 4'h2;
   localparam logic [3:0] ENC_REF = 4'h1;
   localparam logic [3:0] ENC_MRL = 4'h0;

   typedef enum logic [3:0] {
      CMD_INHIBIT, CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE,
      CMD_BST, CMD_PRE, CMD_REF, CMD_MODE_REGISTER_LOAD
   } sbc_cmd_t;

   typedef enum logic [2:0] {
      BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE,
      BK_READ_AP, BK_WRITE_AP, BK_PRECHARGING
   } sbc_bank_st_t;

   typedef enum logic [2:0] {
      MD_NORMAL, MD_REFRESHING, MD_MODE_ACCESS, MD_PRE_ALL,
      MD_SELF_REF, MD_XSR_WAIT, MD_DEEP_POWER_DOWN
   } sbc_mode_t;

   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      sbc_ba_t ba;
      logic [ADDR_W-1:0] addr;
   } sbc_pins_t;

   typedef struct packed {
      sbc_cmd_t cmd;
      logic hit;
      logic ap;
      logic pre_all;
      logic intr;
      logic bst;
   } sbc_bank_ctl_t;
endpackage

// ---- src/sbc_top.sv ----
// Purpose: command decoder and device mode machine of a four-bank SDRAM
// Assumes: controller drives pins on the same mclk edge
// Notes: data path and mode register contents are outside this block
// Summary of operation
// (RL1) Burst terminate cuts the latest registered READ or WRITE burst.
// (RL2) Auto refresh takes its row from the internal counter, ignoring address.
// (RL3) Refresh pattern with CKE low enters self refresh; CKE stays low.
// (RL4) Self refresh keeps contents and bank states without external clock.
// (RL5) Controller enters deep power-down with banks idle and terminate pattern.
// (RL6) Raising CKE leaves deep power-down.
// (RL7) Terminate pattern is burst terminate with CKE high, deep power-down low.
// (RL8) Inhibit and no-operation leave ongoing operations running.
// (RL9) Idle bank accepts activate, refresh, mode register load and precharge.
// (RL10) Precharge to an idle bank acts as no-operation.
// (RL11) Controller issues refresh and mode load only with all banks idle.
// (RL12) Row-active bank accepts READ, WRITE or precharge.
// (RL13) Bursting bank takes new burst, truncating precharge, or burst terminate.
// (RL14) Precharging lasts tRP then idle; controller leaves that bank alone.
// (RL15) Activate holds row-activating state for tRCD, then row active.
// (RL16) Auto precharge burst keeps bank busy until tRP after, then idle.
// (RL17) Controller sends only NOP or inhibit during device-wide busy states.
// (RL18) Auto refresh keeps device busy for tRFC, then all banks idle.
// (RL19) Mode load busy for tMRD, precharge-all busy for tRP.
// (RL20) Command tables act only with CKE high twice and tXSR met.
// (RL21) Commands to another bank follow that bank's own state.
// (RL22) Controller precharges several banks only from legal states.
// (RL23) Auto precharge bank precharges when another bank's burst interrupts it.
// (RL24) Interrupting READ owns the data bus one CAS latency later.
// (RL25) Read interrupting a write makes the previous clock's data final.
// (RL26) Per-bank state register and counters with cycle-count parameters.
// (RL27) Illegal commands are flagged and ignored without changing state.
`timescale 1ns/1ps
module sbc_top
   import sbc_pkg::*;
#(
   parameter int N_BANKS = NUM_BANKS,
   parameter int CL = CAS_LAT,
   parameter int RCD_C = T_RCD_C,
   parameter int RP_C = T_RP_C,
   parameter int RFC_C = T_RFC_C,
   parameter int MRD_C = T_MRD_C,
   parameter int XSR_C = T_XSR_C,
   parameter int WR_C = T_WR_C,
   parameter int BL_C = BURST_LEN,
   parameter int SREF_C = SREF_INT_C
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic cke,
   input wire sbc_pins_t pins,
   output sbc_bank_st_t [N_BANKS-1:0] bank_state,
   output sbc_mode_t dev_mode,
   output sbc_row_t refresh_row,
   output logic burst_stop,
   output sbc_ba_t burst_stop_bank,
   output logic rd_owner_valid,
   output sbc_ba_t rd_owner_bank,
   output logic wr_cut,
   output logic cmd_illegal
);
   localparam sbc_tmr_t LD_RP = sbc_tmr_t'(RP_C - 1);
   localparam sbc_tmr_t LD_RFC = sbc_tmr_t'(RFC_C - 1);
   localparam sbc_tmr_t LD_MRD = sbc_tmr_t'(MRD_C - 1);
   localparam sbc_tmr_t LD_XSR = sbc_tmr_t'(XSR_C - 1);
   localparam sbc_tmr_t LD_SREF = sbc_tmr_t'(SREF_C - 1);

   ////////////////////////////////////////////////////////////////////////
   // Command decode
   logic [3:0] enc;
   sbc_cmd_t cmd;
   logic cke_prev_reg;
   sbc_mode_t mode_reg, mode_next;
   sbc_tmr_t tmr_reg, tmr_next;
   sbc_tmr_t sref_cnt_reg, sref_cnt_next;
   logic tmr_done, sref_tick, table_en, pd_edge, exec_cmd, all_idle;
   logic pre_all, rw_cmd, rw_take, rd_take, bst_ok, bst_take;
   logic ref_take, mode_register_load_take, sref_take, deep_power_down_take;
   logic bad_cmd, busy_mode, wr_other, rw_ok;
   logic [N_BANKS-1:0] idle_vec, wr_vec, bank_bad;
   sbc_bank_ctl_t ctl [N_BANKS];
   logic lb_valid_reg;
   sbc_ba_t lb_bank_reg;
   sbc_row_t row_reg, row_next;
   logic [CL-1:0] rdp_vld_reg;
   sbc_ba_t rdp_bank_reg [CL];
   logic bst_reg, wr_cut_reg, illegal_reg;
   sbc_ba_t bst_bank_reg;

   assign enc = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
   assign cmd = pins.cs_n ? CMD_INHIBIT : // [RL8]
                (enc == ENC_NOP) ? CMD_NOP :
                (enc == ENC_ACT) ? CMD_ACT :
                (enc == ENC_READ) ? CMD_READ :
                (enc == ENC_WRITE) ? CMD_WRITE :
                (enc == ENC_BST) ? CMD_BST :
                (enc == ENC_PRE) ? CMD_PRE :
                (enc == ENC_REF) ? CMD_REF : CMD_MODE_REGISTER_LOAD; // [RL9]
   assign exec_cmd = (cmd != CMD_INHIBIT) && (cmd != CMD_NOP);

   // Tables only with CKE high on both edges and no busy or exit wait
   assign table_en = ce && cke && cke_prev_reg && (mode_reg == MD_NORMAL); // [RL20]
   assign pd_edge = ce && cke_prev_reg && !cke && (mode_reg == MD_NORMAL);
   assign all_idle = &idle_vec;
   assign busy_mode = (mode_reg != MD_NORMAL) && (mode_reg != MD_SELF_REF)
                      && (mode_reg != MD_DEEP_POWER_DOWN);

   assign ref_take = table_en && (cmd == CMD_REF) && all_idle; // [RL9]
   assign mode_register_load_take = table_en && (cmd == CMD_MODE_REGISTER_LOAD)
                                    && all_idle; // [RL9]
   assign sref_take = pd_edge && (cmd == CMD_REF) && all_idle; // [RL3]
   assign deep_power_down_take = pd_edge && (cmd == CMD_BST) && all_idle; // [RL7]
   assign pre_all = table_en && (cmd == CMD_PRE) && pins.addr[AP_BIT]; // [RL19]
   assign rw_cmd = table_en && ((cmd == CMD_READ) || (cmd == CMD_WRITE));
   // Target bank can take a burst, so the burst really interrupts others
   assign rw_ok = (bank_state[pins.ba] == BK_ACTIVE) || (bank_state[pins.ba] == BK_READ)
                  || (bank_state[pins.ba] == BK_WRITE); // [RL12] [RL21]
   assign rw_take = rw_cmd && !(|bank_bad);
   assign rd_take = rw_take && (cmd == CMD_READ);
   assign bst_ok = lb_valid_reg && ((bank_state[lb_bank_reg] == BK_READ)
                   || (bank_state[lb_bank_reg] == BK_WRITE));
   assign bst_take = table_en && (cmd == CMD_BST) && bst_ok; // [RL1] [RL7]
   assign wr_other = rd_take && |wr_vec;

   assign bad_cmd = (table_en && (|bank_bad)) || // [RL27]
                    (table_en && !all_idle && ((cmd == CMD_REF)
                       || (cmd == CMD_MODE_REGISTER_LOAD))) ||
                    (table_en && (cmd == CMD_BST) && !bst_ok) ||
                    (ce && cke && cke_prev_reg && busy_mode && exec_cmd);

   ////////////////////////////////////////////////////////////////////////
   // Banks
   for (genvar i = 0; i < N_BANKS; i++) begin : g_bank // [RL26]
      assign idle_vec[i] = (bank_state[i] == BK_IDLE);
      assign wr_vec[i] = ((bank_state[i] == BK_WRITE) || (bank_state[i] == BK_WRITE_AP))
                         && (pins.ba != sbc_ba_t'(i)); // [RL25]
      assign ctl[i] = '{
         cmd: cmd,
         hit: table_en && (pins.ba == sbc_ba_t'(i)) && !pre_all, // [RL21]
         ap: pins.addr[AP_BIT],
         pre_all: pre_all,
         intr: rw_cmd && rw_ok && (pins.ba != sbc_ba_t'(i)), // [RL23] [RL27]
         bst: bst_take && (lb_bank_reg == sbc_ba_t'(i)) // [RL1]
      };
      sbc_bank #(
         .RCD_C(RCD_C),
         .RP_C(RP_C),
         .WR_C(WR_C),
         .BL_C(BL_C)
      ) u_bank (
         .mclk(mclk),
         .rst(rst),
         .ce(ce),
         .ctl(ctl[i]),
         .state(bank_state[i]),
         .illegal(bank_bad[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Device mode machine
   assign tmr_done = (tmr_reg == TMR_ZERO);
   assign sref_tick = (mode_reg == MD_SELF_REF) && (sref_cnt_reg == TMR_ZERO);

   always_comb begin
      mode_next = mode_reg;
      tmr_next = tmr_done ? tmr_reg : sbc_tmr_t'(tmr_reg - TMR_ONE);
      case (mode_reg)
         MD_NORMAL: begin
            if (sref_take) begin
               mode_next = MD_SELF_REF; // [RL3]
            end else if (deep_power_down_take) begin
               mode_next = MD_DEEP_POWER_DOWN; // [RL7]
            end else if (ref_take) begin
               mode_next = MD_REFRESHING; // [RL18]
               tmr_next = LD_RFC;
            end else if (mode_register_load_take) begin
               mode_next = MD_MODE_ACCESS; // [RL19]
               tmr_next = LD_MRD;
            end else if (pre_all) begin
               mode_next = MD_PRE_ALL; // [RL19]
               tmr_next = LD_RP;
            end
         end
         MD_REFRESHING, MD_MODE_ACCESS, MD_PRE_ALL, MD_XSR_WAIT: begin
            if (tmr_done) mode_next = MD_NORMAL; // [RL18] [RL19] [RL20]
         end
         MD_SELF_REF: begin
            if (cke) begin
               mode_next = MD_XSR_WAIT; // [RL20]
               tmr_next = LD_XSR;
            end
         end
         MD_DEEP_POWER_DOWN: begin
            if (cke) mode_next = MD_NORMAL; // [RL6]
         end
         default: mode_next = MD_NORMAL;
      endcase
   end

   // Internal refresh timer keeps the array alive in self refresh
   assign sref_cnt_next = (mode_reg != MD_SELF_REF) ? LD_SREF :
                          sref_tick ? LD_SREF : sbc_tmr_t'(sref_cnt_reg - TMR_ONE); // [RL4]
   assign row_next = (ref_take || sref_tick) ? sbc_row_t'(row_reg + ROW_ONE) : row_reg; // [RL2]

   always_ff @(posedge mclk) begin
      if (rst) begin
         mode_reg <= MD_NORMAL;
         tmr_reg <= TMR_ZERO;
         sref_cnt_reg <= TMR_ZERO;
         row_reg <= ROW_ZERO;
         cke_prev_reg <= 1'b0;
      end else if (ce) begin
         mode_reg <= mode_next;
         tmr_reg <= tmr_next;
         sref_cnt_reg <= sref_cnt_next;
         row_reg <= row_next;
         cke_prev_reg <= cke;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Burst tracking and data bus hand-over
   always_ff @(posedge mclk) begin
      if (rst) begin
         lb_valid_reg <= 1'b0;
         lb_bank_reg <= '0;
      end else if (ce && rw_take) begin
         lb_valid_reg <= 1'b1; // [RL1]
         lb_bank_reg <= pins.ba;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rdp_vld_reg <= '0;
      end else if (ce) begin
         rdp_vld_reg <= {rdp_vld_reg[CL-2:0], rd_take}; // [RL24]
      end
   end

   always_ff @(posedge mclk) begin
      if (ce) begin
         rdp_bank_reg[0] <= pins.ba;
         for (int k = 1; k < CL; k++) begin
            rdp_bank_reg[k] <= rdp_bank_reg[k-1];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         bst_reg <= 1'b0;
         bst_bank_reg <= '0;
         wr_cut_reg <= 1'b0;
         illegal_reg <= 1'b0;
      end else if (ce) begin
         bst_reg <= bst_take;
         bst_bank_reg <= lb_bank_reg;
         wr_cut_reg <= wr_other; // [RL25]
         illegal_reg <= bad_cmd; // [RL27]
      end
   end

   assign dev_mode = mode_reg;
   assign refresh_row = row_reg;
   assign burst_stop = bst_reg;
   assign burst_stop_bank = bst_bank_reg;
   assign rd_owner_valid = rdp_vld_reg[CL-1];
   assign rd_owner_bank = rdp_bank_reg[CL-1];
   assign wr_cut = wr_cut_reg;
   assign cmd_illegal = illegal_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   a_bst_cuts_burst: // [RL1]
      assert property (bst_take |=> burst_stop && bank_state[burst_stop_bank] == BK_ACTIVE)
      else $error("burst terminate did not end the latest burst");
   a_ref_row_step: // [RL2]
      assert property (ref_take |=> refresh_row == sbc_row_t'($past(refresh_row) + ROW_ONE))
      else $error("refresh row did not advance");
   a_sref_entry: // [RL3]
      assert property (sref_take |=> dev_mode == MD_SELF_REF)
      else $error("self refresh not entered");
   a_sref_hold: // [RL4]
      assert property (ce && dev_mode == MD_SELF_REF && !cke
                       |=> dev_mode == MD_SELF_REF && $stable(bank_state))
      else $error("state changed during self refresh");
   a_dpd_exit: // [RL6]
      assert property (ce && dev_mode == MD_DEEP_POWER_DOWN && cke |=> dev_mode == MD_NORMAL)
      else $error("deep power-down not left on CKE high");
   a_dpd_entry: // [RL7]
      assert property (deep_power_down_take |=> dev_mode == MD_DEEP_POWER_DOWN && !burst_stop)
      else $error("deep power-down not entered");
   a_ref_busy: // [RL18]
      assert property (ref_take |=> dev_mode == MD_REFRESHING && tmr_reg == LD_RFC)
      else $error("refresh did not start its busy time");
   a_load_busy: // [RL19]
      assert property (mode_register_load_take |=> dev_mode == MD_MODE_ACCESS && tmr_reg == LD_MRD)
      else $error("mode load did not start its busy time");
   a_busy_ends: // [RL19]
      assert property (ce && busy_mode && tmr_done |=> dev_mode == MD_NORMAL)
      else $error("busy state outlived its timer");
   a_xsr_entry: // [RL20]
      assert property (ce && dev_mode == MD_SELF_REF && cke
                       |=> dev_mode == MD_XSR_WAIT && tmr_reg == LD_XSR)
      else $error("self refresh exit did not start its wait");
   a_rd_owner: // [RL24]
      assert property (disable iff (rst || !ce) rd_take |-> ##CL rd_owner_valid)
      else $error("read did not take the bus after CAS latency");
   a_wr_cut: // [RL25]
      assert property (wr_other |=> wr_cut)
      else $error("write cut not flagged");
   a_pre_all_busy: // [RL19]
      assert property (pre_all |=> dev_mode == MD_PRE_ALL && tmr_reg == LD_RP)
      else $error("precharge all did not start its busy time");
   a_nop_quiet: // [RL8]
      assert property (ce && !exec_cmd |=> !cmd_illegal)
      else $error("no-operation flagged as illegal");
   a_dpd_hold: // [RL6]
      assert property (ce && dev_mode == MD_DEEP_POWER_DOWN && !cke
                       |=> dev_mode == MD_DEEP_POWER_DOWN)
      else $error("deep power-down left with CKE low");
   a_rw_legal: // [RL12]
      assert property (rw_cmd && !rw_ok |=> cmd_illegal)
      else $error("burst to a closed bank not flagged");
   a_sref_row: // [RL4]
      assert property (ce && sref_tick |=> refresh_row == sbc_row_t'($past(refresh_row) + ROW_ONE))
      else $error("self refresh row did not advance");

   c_self_refresh: cover property (sref_take ##[1:50] dev_mode == MD_XSR_WAIT);
   c_deep_pd: cover property (deep_power_down_take ##[1:50] dev_mode == MD_NORMAL);
   c_burst_stop: cover property (bst_take);
   c_read_interrupts_write: cover property (wr_other);
   c_pre_all: cover property (pre_all ##1 dev_mode == MD_PRE_ALL);
endmodule

// ---- test/sbc_ctl_model.sv ----
// Purpose: memory controller model driving the command pins
// Assumes: commands start at the falling edge, NOP returns on the sampling edge
// Notes: between commands the address lines show the inverse of the last value
`timescale 1ns/1ps
module sbc_ctl_model
   import sbc_pkg::*;
(
   input wire logic mclk,
   output logic cke,
   output sbc_pins_t pins
);
   initial begin
      cke = 1'b1;
      pins = {ENC_NOP, 2'h0, 13'h0000};
   end
   ////////////////////////////////////////
   // One command for the next rising edge, then NOP; cke keeps its level
   // Caller orders refresh, mode load, deep power-down after idle banks
   // NOP only during busy states unless refusal is wanted
   task automatic issue(input logic [3:0] enc, input sbc_ba_t ba, input logic [12:0] a,
         input logic ck);
      pins = {enc, ba, a};
      cke = ck;
      @(posedge mclk);
      pins <= {ENC_NOP, ~ba, ~a};
      @(negedge mclk);
   endtask
endmodule

// ---- test/sbc_top_tb.sv ----
// Purpose: self-checking bench of the bank command block
// Assumes: default timing parameters
// Notes: inputs change at the falling edge, except the NOP after each command, which returns at the rising edge
`timescale 1ns/1ps
module sbc_top_tb;
   import sbc_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic cke;
   sbc_pins_t pins;
   sbc_bank_st_t [3:0] bs;
   sbc_mode_t md;
   sbc_row_t row;
   logic bstop, rdv, wcut, ill;
   sbc_ba_t bstop_bank, rd_bank;
   int n_errors = 0;
   int total_checks = 0;
   int i;
   always #20 mclk = ~mclk;
   sbc_ctl_model ctl (.mclk(mclk), .cke(cke), .pins(pins));
   sbc_top dut (.mclk(mclk), .rst(rst), .ce(ce), .cke(cke), .pins(pins), .bank_state(bs),
      .dev_mode(md), .refresh_row(row), .burst_stop(bstop), .burst_stop_bank(bstop_bank),
      .rd_owner_valid(rdv), .rd_owner_bank(rd_bank), .wr_cut(wcut), .cmd_illegal(ill));
   ////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wait_mode(input sbc_mode_t m);
      for (i = 0; i < 20 && md !== m; i++) @(negedge mclk);
      chk("mode wait", md, m);
      if (md !== m) give_verdict();
   endtask
   ////////////////////////////////////////
   task automatic t_refresh();
      ctl.issue(ENC_REF, 2'h2, 13'h1ABC, 1'b1);
      chk("refreshing", md, MD_REFRESHING);
      chk("ref row", row, ROW_ONE);
      ctl.issue(ENC_ACT, 2'h2, 13'h0000, 1'b1);
      chk("busy act", ill, 1'b1);
      @(negedge mclk);
      chk("ref done", md, MD_NORMAL);
      chk("no act", bs[2], BK_IDLE);
   endtask
   task automatic t_idle();
      ctl.issue(ENC_MRL, 2'h0, 13'h0032, 1'b1);
      chk("mode access", md, MD_MODE_ACCESS);
      repeat (2) @(negedge mclk);
      chk("mode done", md, MD_NORMAL);
      ctl.issue(ENC_PRE, 2'h1, 13'h0000, 1'b1);
      chk("pre idle", ill, 1'b0);
      chk("pre idle st", bs[1], BK_IDLE);
      ctl.issue(ENC_READ, 2'h3, 13'h0000, 1'b1);
      chk("read idle", ill, 1'b1);
      chk("read idle st", bs[3], BK_IDLE);
      ctl.issue(ENC_NOP, 2'h3, 13'h0000, 1'b1);
      chk("nop", bs, {4{BK_IDLE}});
   endtask
   task automatic t_burst();
      ctl.issue(ENC_ACT, 2'h0, 13'h0005, 1'b1);
      chk("activating", bs[0], BK_ACTIVATING);
      @(negedge mclk);
      chk("active", bs[0], BK_ACTIVE);
      ctl.issue(ENC_READ, 2'h0, 13'h0000, 1'b1);
      chk("read", bs[0], BK_READ);
      ctl.issue(ENC_BST, 2'h3, 13'h0000, 1'b1);
      chk("stop", bstop, 1'b1);
      chk("stop bank", bstop_bank, 2'h0);
      chk("after stop", bs[0], BK_ACTIVE);
   endtask
   task automatic t_inter();
      ctl.issue(ENC_ACT, 2'h1, 13'h0009, 1'b1);
      @(negedge mclk);
      ctl.issue(ENC_WRITE, 2'h0, 13'h0000, 1'b1);
      chk("write", bs[0], BK_WRITE);
      ctl.issue(ENC_READ, 2'h1, 13'h0000, 1'b1);
      chk("wr cut", wcut, 1'b1);
      chk("read b1", bs[1], BK_READ);
      repeat (2) @(negedge mclk);
      chk("rd owner", rdv, 1'b1);
      chk("rd bank", rd_bank, 2'h1);
      ctl.issue(ENC_PRE, 2'h0, 13'h0400, 1'b1);
      chk("pre all", md, MD_PRE_ALL);
      @(negedge mclk);
      chk("pre done", md, MD_NORMAL);
      chk("banks idle", bs, {4{BK_IDLE}});
   endtask
   task automatic t_autopre();
      ctl.issue(ENC_ACT, 2'h2, 13'h0011, 1'b1);
      @(negedge mclk);
      ctl.issue(ENC_READ, 2'h2, 13'h0400, 1'b1);
      chk("read ap", bs[2], BK_READ_AP);
      for (i = 0; i < 12 && bs[2] !== BK_IDLE; i++) @(negedge mclk);
      chk("ap idle", bs[2], BK_IDLE);
      ctl.issue(ENC_ACT, 2'h1, 13'h0002, 1'b1);
      ctl.issue(ENC_ACT, 2'h2, 13'h0011, 1'b1);
      @(negedge mclk);
      ctl.issue(ENC_WRITE, 2'h2, 13'h0400, 1'b1);
      chk("write ap", bs[2], BK_WRITE_AP);
      ctl.issue(ENC_READ, 2'h1, 13'h0000, 1'b1);
      chk("ap cut", bs[2], BK_PRECHARGING);
      chk("ap wr cut", wcut, 1'b1);
      ctl.issue(ENC_PRE, 2'h1, 13'h0000, 1'b1);
      chk("pre cut", bs[1], BK_PRECHARGING);
      @(negedge mclk);
      chk("all idle", bs, {4{BK_IDLE}});
   endtask
   task automatic t_power();
      ctl.issue(ENC_REF, 2'h0, 13'h0000, 1'b0);
      chk("self ref", md, MD_SELF_REF);
      ctl.issue(ENC_ACT, 2'h1, 13'h0000, 1'b0);
      repeat (8) @(negedge mclk);
      chk("still self", md, MD_SELF_REF);
      chk("kept banks", bs, {4{BK_IDLE}});
      ctl.issue(ENC_NOP, 2'h0, 13'h0000, 1'b1);
      chk("xsr", md, MD_XSR_WAIT);
      wait_mode(MD_NORMAL);
      ctl.issue(ENC_BST, 2'h0, 13'h0000, 1'b0);
      chk("deep pd", md, MD_DEEP_POWER_DOWN);
      repeat (3) @(negedge mclk);
      ctl.issue(ENC_NOP, 2'h0, 13'h0000, 1'b1);
      chk("pd exit", md, MD_NORMAL);
      ctl.issue(ENC_ACT, 2'h1, 13'h0003, 1'b1);
      chk("act after", bs[1], BK_ACTIVATING);
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (5) @(negedge mclk);
      rst = 1'b0;
      repeat (2) @(negedge mclk);
      t_refresh();
      t_idle();
      t_burst();
      t_inter();
      t_autopre();
      t_power();
      give_verdict();
   end
endmodule
